/* bridge_pwm_pkg.sv */
// shared types and constants for the enhanced bridge pwm output stage
package bridge_pwm_pkg;

   // ==========================================
   // control register layout
   localparam int CFG_MSB = 7;
   localparam int CFG_LSB = 6;
   localparam int DUTY_LO_MSB = 5;
   localparam int DUTY_LO_LSB = 4;
   localparam int POL_MSB = 3;
   localparam int POL_LSB = 0;
   localparam logic [7:0] CTRL_RESET = 8'h00;

   // polarity field: upper pair must read 11 for pwm, bit0 inverts a/c, bit1 inverts b/d
   localparam logic [1:0] POL_PWM_ON = 2'h3;
   localparam int POL_AC_LOW_BIT = 0;
   localparam int POL_BD_LOW_BIT = 1;

   // ==========================================
   // timing: one instruction cycle is four oscillator periods
   localparam int TOSC_PER_INSTR = 4;
   localparam int DUTY_W = 10;
   localparam int DB_CNT_W = 10;
   localparam logic [3:0] PS_LAST_1 = 4'h0;
   localparam logic [3:0] PS_LAST_4 = 4'h3;
   localparam logic [3:0] PS_LAST_16 = 4'hF;
   localparam logic [1:0] FINE_LAST = 2'h3;

   // output configurations
   typedef enum logic [1:0] {
      CFG_SINGLE = 2'h0,
      CFG_FULL_FWD = 2'h1,
      CFG_HALF = 2'h2,
      CFG_FULL_REV = 2'h3
   } out_cfg_t;

   // control register as software writes it
   typedef struct packed {
      out_cfg_t cfg;
      logic [1:0] duty_lo;
      logic [3:0] pol;
   } ctrl_t;

   // pin group: level per output and whether the pwm owns the pin
   typedef struct packed {
      logic [3:0] level;
      logic [3:0] own;
   } bridge_out_t;

endpackage

/* deadband_delay.sv */
// turn-on delay for one half-bridge output; turn-off passes at once
`timescale 1ns/1ps
module deadband_delay (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic sig,
   input wire logic [bridge_pwm_pkg::DB_CNT_W-1:0] target,
   output logic q
);

   typedef struct packed {
      logic prev;
      logic [bridge_pwm_pkg::DB_CNT_W-1:0] cnt;
   } db_state_t;

   db_state_t st_r;
   db_state_t st_nxt;

   // ==========================================
   // count oscillator periods since the last inactive-to-active edge
   always_comb begin
      st_nxt = st_r;
      st_nxt.prev = sig;
      if (!sig) begin
         st_nxt.cnt = '0;
      end else if (!st_r.prev) begin
         st_nxt.cnt = {{(bridge_pwm_pkg::DB_CNT_W-1){1'b0}}, 1'b1};
      end else if (st_r.cnt < target) begin
         st_nxt.cnt = st_r.cnt + 1'b1;
      end
   end

   // a pulse shorter than the delay never shows, so the output stays off
   assign q = sig && ((target == '0) || (st_r.prev && st_r.cnt >= target));

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

endmodule

/* enhanced_bridge_pwm.sv */
// enhanced pwm output stage driving single, half-bridge or full-bridge outputs
`timescale 1ns/1ps
module enhanced_bridge_pwm (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic timer_on,
   input wire logic [1:0] prescale_sel,
   input wire logic [7:0] period_register,
   input wire logic [7:0] duty_high_byte,
   input wire bridge_pwm_pkg::ctrl_t pwm_control_reg,
   input wire logic [7:0] deadband_delay_reg,
   output bridge_pwm_pkg::bridge_out_t pins,
   output logic period_wrap,
   output logic running
);

   typedef struct packed {
      logic [3:0] ps_cnt;
      logic [bridge_pwm_pkg::DUTY_W-1:0] fine_cnt;
      // period value in force for the running cycle; the timer never compares the live input
      logic [7:0] per;
      bridge_pwm_pkg::out_cfg_t cfg;
      logic [3:0] pol;
      logic [bridge_pwm_pkg::DUTY_W-1:0] duty;
      // deadband in use, and whether the duty boundary already loaded it this cycle
      logic [7:0] db;
      logic db_loaded;
      logic run;
      logic wrap;
      bridge_pwm_pkg::bridge_out_t pins;
   } pwm_state_t;

   pwm_state_t st_r;
   pwm_state_t st_nxt;

   logic pwm_on;
   logic tick;
   logic period_end;
   logic duty_end;
   logic raw_on;
   logic raw_off;
   logic dly_a;
   logic dly_b;
   logic [bridge_pwm_pkg::DB_CNT_W-1:0] db_target;
   logic [3:0] act;

   // ==========================================
   // helpers
   // last prescaler count for the selected ratio 1, 4 or 16
   function automatic logic [3:0] ps_last(input logic [1:0] sel);
      case (sel)
         2'h0: ps_last = bridge_pwm_pkg::PS_LAST_1;
         2'h1: ps_last = bridge_pwm_pkg::PS_LAST_4;
         default: ps_last = bridge_pwm_pkg::PS_LAST_16;
      endcase
   endfunction

   // apply polarity: a/c share one invert bit, b/d the other
   function automatic logic [3:0] polar(input logic [3:0] a, input logic [3:0] p);
      logic ac;
      logic bd;
      ac = p[bridge_pwm_pkg::POL_AC_LOW_BIT];
      bd = p[bridge_pwm_pkg::POL_BD_LOW_BIT];
      polar = a ^ {bd, ac, bd, ac};
   endfunction

   // ==========================================
   // timebase and boundaries
   // limitations a user must know:
   // - mode, polarity, duty and period move in only at a period end, so a change made
   //   while running shows up to one full period late
   // - the enable is shadowed only when switching on: switching off releases the pins two clocks later, without waiting for the period end, which is
   //   the safe direction for the power switches
   // - a duty at or above the period has no duty boundary, so a new deadband value then
   //   waits for the period end
   // the fine count steps once per prescale slot, so its low pair acts as the oscillator phase only at ratio 1
   assign pwm_on = (pwm_control_reg.pol[3:2] == bridge_pwm_pkg::POL_PWM_ON) && timer_on;
   // the prescaler compares with the live ratio; a change can stretch one slot to as many as twenty cycles
   assign tick = timer_on && (st_r.ps_cnt == ps_last(prescale_sel));
   // comparing with the shadowed period keeps the fine count from running past a
   // freshly lowered period and wrapping through its whole range
   assign period_end = tick
      && (st_r.fine_cnt == {st_r.per, bridge_pwm_pkg::FINE_LAST});
   assign duty_end = tick && (st_r.fine_cnt + 1'b1 == st_r.duty);
   assign raw_on = st_r.run && (st_r.fine_cnt < st_r.duty);
   assign raw_off = st_r.run && !raw_on;

   localparam int DB_CNT_W = bridge_pwm_pkg::DB_CNT_W;

   // delay in oscillator periods: four per instruction cycle, only in half-bridge
   // ten bits hold the largest delay, 255 instruction cycles of four periods each
   assign db_target = (st_r.cfg == bridge_pwm_pkg::CFG_HALF)
      ? DB_CNT_W'(st_r.db) * DB_CNT_W'(bridge_pwm_pkg::TOSC_PER_INSTR)
      : '0;

   // one turn-on delay per half-bridge output; out_b's runs from the fall of the raw pwm
   deadband_delay u_delay_a (
      .mclk(mclk),
      .rst_n(rst_n),
      .sig(raw_on),
      .target(db_target),
      .q(dly_a)
   );

   deadband_delay u_delay_b (
      .mclk(mclk),
      .rst_n(rst_n),
      .sig(raw_off),
      .target(db_target),
      .q(dly_b)
   );

   // ==========================================
   // next state
   always_comb begin
      st_nxt = st_r;
      act = 4'h0;
      st_nxt.wrap = period_end;
      // the prescaler holds while the timer is stopped, so its phase resumes where it left off
      if (timer_on) begin
         st_nxt.ps_cnt = tick ? 4'h0 : st_r.ps_cnt + 1'b1;
      end
      if (period_end) begin
         st_nxt.fine_cnt = '0;
      end else if (tick) begin
         st_nxt.fine_cnt = st_r.fine_cnt + 1'b1;
      end
      // deadband loads at the duty boundary if the cycle has one, and again at every period end
      if ((duty_end && !st_r.db_loaded) || period_end) begin
         st_nxt.db = deadband_delay_reg;
         st_nxt.db_loaded = !period_end;
      end
      // shadows move to active copies only at the period boundary, never mid-cycle
      if (period_end) begin
         st_nxt.per = period_register;
         st_nxt.cfg = pwm_control_reg.cfg;
         st_nxt.pol = pwm_control_reg.pol;
         st_nxt.duty = {duty_high_byte, pwm_control_reg.duty_lo};
         st_nxt.run = pwm_on;
      end
      // the run flag drops as soon as the stage is disabled; the pins let go a cycle later
      if (!pwm_on) begin
         st_nxt.run = 1'b0;
      end
      // active levels per configuration, before polarity
      // single drives out_a only; half pairs a with its complement on b; the two
      // full-bridge directions hold one pin on and modulate the diagonal partner
      case (st_r.cfg)
         bridge_pwm_pkg::CFG_SINGLE: begin
            act = {3'h0, raw_on};
            st_nxt.pins.own = 4'h1;
         end
         bridge_pwm_pkg::CFG_HALF: begin
            act = {2'h0, dly_b, dly_a};
            st_nxt.pins.own = 4'h3;
         end
         bridge_pwm_pkg::CFG_FULL_FWD: begin
            act = {raw_on, 2'h0, st_r.run};
            st_nxt.pins.own = 4'hF;
         end
         bridge_pwm_pkg::CFG_FULL_REV: begin
            act = {1'b0, st_r.run, raw_on, 1'b0};
            st_nxt.pins.own = 4'hF;
         end
         default: begin
            act = 4'h0;
            st_nxt.pins.own = 4'h0;
         end
      endcase
      // unowned pins still carry the polarity-inactive level, so a later claim starts clean
      if (!st_r.run) begin
         st_nxt.pins.own = 4'h0;
      end
      st_nxt.pins.level = polar(act, st_r.pol);
   end

   // ==========================================
   // state register
   // reset leaves the stage off, every pin released and all shadows empty
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // every output comes straight from a flip-flop
   assign pins = st_r.pins;
   assign period_wrap = st_r.wrap;
   assign running = st_r.run;

endmodule

/* bridge_load.sv */
// stand-in for the power switch drivers: counts cycles where both switches of a leg conduct
`timescale 1ns/1ps
module bridge_load (
   input wire logic mclk,
   input wire bridge_pwm_pkg::bridge_out_t pins,
   input wire logic [3:0] pol,
   output int shoot
);
   logic [3:0] sw_on;
   // =====
   // a pin not claimed by the pwm stays with the port latch, which holds its switch off
   assign sw_on = pins.own & (pins.level ^ {pol[1:0], pol[1:0]});
   initial shoot = 0;
   // legs are a/b and c/d; any overlap on a leg would short the supply
   always @(posedge mclk) begin
      if ((sw_on[0] && sw_on[1]) || (sw_on[2] && sw_on[3])) shoot <= shoot + 1;
   end
endmodule

/* enhanced_bridge_pwm_assertions.sv */
// concurrent checks on the enhanced bridge pwm ports
`timescale 1ns/1ps
module enhanced_bridge_pwm_assertions (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic timer_on,
   input wire logic [1:0] prescale_sel,
   input wire logic [7:0] period_register,
   input wire logic [7:0] duty_high_byte,
   input wire bridge_pwm_pkg::ctrl_t pwm_control_reg,
   input wire logic [7:0] deadband_delay_reg,
   input wire bridge_pwm_pkg::bridge_out_t pins,
   input wire logic period_wrap,
   input wire logic running
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   logic [3:0] act;
   logic [15:0] cnt_r;
   logic [15:0] exp_len;
   logic ok_r;
   logic on;
   // =====
   // active view of each pin; only valid while the settings are not changed mid-run
   assign act = pins.level ^ {pwm_control_reg.pol[1:0], pwm_control_reg.pol[1:0]};
   assign on = pwm_control_reg.pol[3:2] == 2'h3;
   assign exp_len = 16'(4 * (int'(period_register) + 1)
                    * ((prescale_sel == 2'h0) ? 1 : (prescale_sel == 2'h1) ? 4 : 16));
   // cycles since last wrap; trusted only if the settings stood still the whole period
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= 16'h0000;
         ok_r <= 1'b0;
      end else begin
         cnt_r <= period_wrap ? 16'h0001 : cnt_r + 16'h0001;
         if (!running || !$stable(period_register) || !$stable(prescale_sel)) ok_r <= 1'b0;
         else if (period_wrap) ok_r <= 1'b1;
      end
   end
   property p_len;
      period_wrap && ok_r && $stable(period_register) && $stable(prescale_sel)
         |-> cnt_r == exp_len;
   endproperty
   a_len: assert property (p_len) else $error("period length wrong");
   property p_pulse;
      period_wrap |=> !period_wrap [*3];
   endproperty
   a_pulse: assert property (p_pulse) else $error("wrap pulse too close");
   property p_shape;
      pins.own == 4'h0 || pins.own == 4'h1 || pins.own == 4'h3 || pins.own == 4'hF;
   endproperty
   a_shape: assert property (p_shape) else $error("pin ownership not a mode");
   property p_single;
      on && pins.own == 4'h1 |-> act[3:1] == 3'h0;
   endproperty
   a_single: assert property (p_single) else $error("single mode drives b to d");
   property p_half;
      on && pins.own == 4'h3 |-> !(act[0] && act[1]) && act[3:2] == 2'h0;
   endproperty
   a_half: assert property (p_half) else $error("half bridge overlap");
   property p_full;
      on && pins.own == 4'hF |-> (act[0] ^ act[2]) && !(act[0] && act[1]) && !(act[2] && act[3]);
   endproperty
   a_full: assert property (p_full) else $error("full bridge pair wrong");
   property p_start;
      $rose(|pins.own) |-> $past(running);
   endproperty
   a_start: assert property (p_start) else $error("pins claimed before run");
   property p_run;
      $rose(running) |-> period_wrap || $past(period_wrap);
   endproperty
   a_run: assert property (p_run) else $error("start not at period end");
   property p_off;
      !(on && timer_on) [*2] |=> !running && pins.own == 4'h0;
   endproperty
   a_off: assert property (p_off) else $error("pwm kept running when off");
endmodule
bind enhanced_bridge_pwm enhanced_bridge_pwm_assertions chk_u (.mclk, .rst_n, .timer_on,
   .prescale_sel, .period_register, .duty_high_byte, .pwm_control_reg, .deadband_delay_reg,
   .pins, .period_wrap, .running);

/* enhanced_bridge_pwm_tb.sv */
// self-checking bench for the enhanced bridge pwm output stage
`timescale 1ns/1ps
module enhanced_bridge_pwm_tb;
   logic mclk, rst_n, timer_on, period_wrap, running;
   logic [1:0] prescale_sel;
   logic [7:0] period_register, duty_high_byte, deadband_delay_reg;
   logic [3:0] cur_pol;
   bridge_pwm_pkg::ctrl_t ctrl;
   bridge_pwm_pkg::bridge_out_t pins;
   int shoot, n_mismatch, n_compared, len, hi[4];
   enhanced_bridge_pwm dut_u (.mclk(mclk), .rst_n(rst_n), .timer_on(timer_on),
      .prescale_sel(prescale_sel), .period_register(period_register),
      .duty_high_byte(duty_high_byte), .pwm_control_reg(ctrl),
      .deadband_delay_reg(deadband_delay_reg), .pins(pins), .period_wrap(period_wrap),
      .running(running));
   bridge_load load_u (.mclk(mclk), .pins(pins), .pol(cur_pol), .shoot(shoot));
   // =====
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_compared++;
      if (exp !== got) begin
         n_mismatch++;
         $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
      end
   endtask
   task automatic report_and_stop();
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // bounded wait; leaves the bench at the falling edge that shows the wrap pulse
   task automatic wait_wrap();
      int n;
      n = 0;
      do begin
         @(negedge mclk);
         n++;
      end while (period_wrap !== 1'b1 && n < 600);
      if (n >= 600) check("wrap wait", 16'h0001, 16'h0000);
   endtask
   // counts active, owned cycles per pin over one period; the pins trail the wrap pulse
   // by one register cycle, so counting starts after this wrap and ends on the next one
   task automatic measure();
      for (int i = 0; i < 4; i++) hi[i] = 0;
      len = 0;
      do begin
         @(negedge mclk);
         for (int i = 0; i < 4; i++) hi[i] += (pins.level[i] ^ cur_pol[i % 2]) & pins.own[i];
         len++;
      end while (period_wrap !== 1'b1 && len < 600);
   endtask
   task automatic run(input bridge_pwm_pkg::out_cfg_t cfg, input logic [3:0] pol,
         input logic [7:0] p, input logic [1:0] ps, input logic [9:0] d, input logic [7:0] db);
      int r, l, dt, e[4];
      r = (ps == 2'h0) ? 1 : (ps == 2'h1) ? 4 : 16;
      l = 4 * (p + 1) * r;
      dt = (d * r > l) ? l : d * r;
      case (cfg)
         bridge_pwm_pkg::CFG_SINGLE: e = '{dt, 0, 0, 0};
         bridge_pwm_pkg::CFG_HALF: e = '{(dt > 4 * db) ? dt - 4 * db : 0,
                                         (l - dt > 4 * db) ? l - dt - 4 * db : 0, 0, 0};
         bridge_pwm_pkg::CFG_FULL_FWD: e = '{l, 0, 0, dt};
         default: e = '{0, dt, l, 0};
      endcase
      // switch off first so the new polarity is never applied to a running stage
      ctrl.pol = 4'h0;
      repeat (4) @(negedge mclk);
      cur_pol = pol;
      period_register = p;
      prescale_sel = ps;
      duty_high_byte = d[9:2];
      deadband_delay_reg = db;
      ctrl = '{cfg, d[1:0], pol};
      @(negedge mclk);
      check("own before start", 16'h0000, 16'(pins.own));
      repeat (3) wait_wrap();
      measure();
      check("period", 16'(l), 16'(len));
      check("own", (cfg == bridge_pwm_pkg::CFG_SINGLE) ? 16'h0001 :
            (cfg == bridge_pwm_pkg::CFG_HALF) ? 16'h0003 : 16'h000F, 16'(pins.own));
      for (int i = 0; i < 4; i++) begin
         check($sformatf("active cycles out %0d", i), 16'(e[i]), 16'(hi[i]));
      end
   endtask
   // =====
   initial begin
      {rst_n, timer_on, prescale_sel, period_register, duty_high_byte} = '0;
      deadband_delay_reg = 8'h00;
      ctrl = bridge_pwm_pkg::CTRL_RESET;
      cur_pol = 4'h0;
      repeat (6) @(negedge mclk);
      rst_n = 1'b1;
      timer_on = 1'b1;
      run(bridge_pwm_pkg::CFG_SINGLE, 4'hC, 8'h02, 2'h0, 10'h005, 8'h00);
      run(bridge_pwm_pkg::CFG_HALF, 4'hC, 8'h03, 2'h0, 10'h006, 8'h01);
      run(bridge_pwm_pkg::CFG_HALF, 4'hF, 8'h03, 2'h0, 10'h006, 8'h02);
      run(bridge_pwm_pkg::CFG_FULL_FWD, 4'hF, 8'h02, 2'h1, 10'h005, 8'h03);
      run(bridge_pwm_pkg::CFG_FULL_REV, 4'hC, 8'h01, 2'h3, 10'h003, 8'h00);
      run(bridge_pwm_pkg::CFG_SINGLE, 4'hC, 8'h02, 2'h0, 10'h03C, 8'h00);
      // new duty written just after a wrap must wait for the next period
      duty_high_byte = 8'h01;
      ctrl.duty_lo = 2'h0;
      measure();
      check("duty held", 16'h000C, 16'(hi[0]));
      measure();
      check("duty loaded", 16'h0004, 16'(hi[0]));
      check("shoot-through", 16'h0000, 16'(shoot));
      report_and_stop();
   end
   // cut a hang short well past the expected run length
   initial begin
      repeat (20000) @(posedge mclk);
      n_mismatch++;
      report_and_stop();
   end
endmodule
